// ### ccdm_chk.sv
// Port checks for the clock conditioning block.
// Assumes binding into ccdm_clock_cond; one clock domain, async reset.
module ccdm_chk
  import ccdm_pkg::*;
(
  // System
  input wire logic        I_SYS_CLK,
  input wire logic        I_SYS_RST,
  // APB
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  // Clocks and status
  input wire logic        O_PRIMARY_GLOBAL_CLOCK,
  input wire logic        O_SECONDARY_GLOBAL_CLOCK,
  input wire logic        O_LOCK,
  input wire logic        O_LOOP_POWER_DOWN
);
  // ****************************************
  // Access decode
  // ****************************************
  logic unmapped;
  logic rd_acc;
  // Unmapped places and the read access phase
  assign unmapped = !(I_PADDR inside {OFS_CTRL, OFS_DIV, OFS_SEL, OFS_DLY, OFS_STATUS});
  assign rd_acc   = I_PSEL && I_PENABLE && !I_PWRITE;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  // ****************************************
  // Properties
  // ****************************************
  property p_ready; O_PREADY; endproperty
  a_ready: assert property (p_ready) else $error("ready not high");
  property p_err; O_PSLVERR == (I_PSEL && I_PENABLE && unmapped); endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_unm_rd; rd_acc && unmapped |-> O_PRDATA == 32'h0; endproperty
  a_unm_rd: assert property (p_unm_rd) else $error("unmapped read not zero");
  property p_sts; rd_acc && I_PADDR == OFS_STATUS |-> O_PRDATA[1:0] == $past({O_LOOP_POWER_DOWN, O_LOCK}); endproperty
  a_sts: assert property (p_sts) else $error("status bits differ from outputs");
  property p_pd_lock; O_LOOP_POWER_DOWN |=> !O_LOCK; endproperty
  a_pd_lock: assert property (p_pd_lock) else $error("lock high while powered down");
  property p_relock; $fell(O_LOCK) |=> !O_LOCK [*8]; endproperty
  a_relock: assert property (p_relock) else $error("lock back too soon");
  property p_rose; $rose(O_LOCK) |-> !$past(O_LOOP_POWER_DOWN); endproperty
  a_rose: assert property (p_rose) else $error("lock rose in power down");
  property p_rst;
    $fell(I_SYS_RST) |-> !O_LOCK && !O_LOOP_POWER_DOWN && !O_PRIMARY_GLOBAL_CLOCK && !O_SECONDARY_GLOBAL_CLOCK;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule : ccdm_chk

bind ccdm_clock_cond ccdm_chk u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_PRIMARY_GLOBAL_CLOCK(O_PRIMARY_GLOBAL_CLOCK),
  .O_SECONDARY_GLOBAL_CLOCK(O_SECONDARY_GLOBAL_CLOCK), .O_LOCK(O_LOCK),
  .O_LOOP_POWER_DOWN(O_LOOP_POWER_DOWN));

// ### ccdm_clock_cond.sv
// Clock conditioning block: reference select, dividers, delay taps,
// digital loop with four oscillator phases, bypass and lock.
// Assumes clock pins are asynchronous to I_SYS_CLK and slower than it.
// Functional notes
// - Input divider divides reference by 1 to 16.
// - Feedback divider multiplies reference by 1 to 64.
// - Each output path has its own divider of 1 to 4.
// - Each output is the loop output over its own divider.
// - Locked output equals reference times m over n times output divider.
// - Delays in both outputs and feedback, 250 ps steps, up to 8 ns.
// - Output delay lags outputs; feedback delay advances them.
// - Primary output may take phase 0, 90, 180 or 270.
// - Secondary output always uses the zero phase.
// - Primary and secondary may bypass the loop independently.
// - Primary bypass skips input divider; its divider and delay stay usable.
// - Both bypassed: loop and input divider skipped, core powered down.
// - Second reference feeds only the secondary, only when bypassed.
// - Lock output rises once the loop has locked.
// - Bypassing both outputs powers the core down; also a dynamic control bit.
// - Feedback source is own output, internal path or external input.
// - Settings come from static bits or the register interface.
// - One mode bit switches static and dynamic while running.
// - Reference source is pad, differential pair or internal signal.
// - Lock output is low whenever not locked.
// - Mode bit 0 means static configuration.
// - Primary select codes 100 to 111 pick phases 0 to 270.
// - Feedback select 00 ground, 01 delayed, 10 phase 0, 11 external.
//
// The APB register port and the address map were chosen for this implementation.
module ccdm_clock_cond
  import ccdm_pkg::*;
#(
  parameter int P_IN_DIV  = 1,
  parameter int P_FB_MUL  = 1,
  parameter int P_U_DIV   = 1,
  parameter int P_V_DIV   = 1,
  parameter logic [2:0] P_PSEL  = PSEL_PH0,
  parameter logic [1:0] P_SSEL  = SSEL_LOOP,
  parameter logic [1:0] P_FEEDBACK_SOURCE_SELECT = FEEDBACK_SOURCE_SELECT_PH0,
  parameter logic [1:0] P_SRC   = SRC_PAD,
  parameter logic [5:0] P_DLYP  = 6'h00,
  parameter logic [5:0] P_DLYS  = 6'h00,
  parameter logic [5:0] P_DLYF  = 6'h00
) (
  // System
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Clock inputs
  input  wire logic        I_GLOBAL_PAD_CLK,
  input  wire logic        I_DIFFERENTIAL_CLOCK_PAIR,
  input  wire logic        I_INTERNAL_CLK,
  input  wire logic        I_SECONDARY_REFERENCE_CLOCK,
  input  wire logic        I_EXTERNAL_FEEDBACK_INPUT,
  // Clock outputs and status
  output logic             O_PRIMARY_GLOBAL_CLOCK,
  output logic             O_SECONDARY_GLOBAL_CLOCK,
  output logic             O_LOCK,
  output logic             O_LOOP_POWER_DOWN
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (P_IN_DIV < 1 || P_IN_DIV > IN_DIV_MAX) begin : g_bad_n
    $error("Static input divider out of range");
  end
  if (P_FB_MUL < 1 || P_FB_MUL > FB_MUL_MAX) begin : g_bad_m
    $error("Static feedback factor out of range");
  end
  if (P_U_DIV < 1 || P_U_DIV > OUT_DIV_MAX || P_V_DIV < 1 || P_V_DIV > OUT_DIV_MAX) begin : g_bad_o
    $error("Static output divider out of range");
  end

  localparam logic [3:0] S_N = 4'(P_IN_DIV - 1);
  localparam logic [5:0] S_M = 6'(P_FB_MUL - 1);
  localparam logic [1:0] S_U = 2'(P_U_DIV - 1);
  localparam logic [1:0] S_V = 2'(P_V_DIV - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [4:0]             s1;
    logic [4:0]             s2;
    logic                   mode;
    logic                   pd_reg;
    logic [3:0]             n_m1;
    logic [5:0]             m_m1;
    logic [1:0]             u_m1;
    logic [1:0]             v_m1;
    logic [2:0]             psel;
    logic [1:0]             ssel;
    logic [1:0]             feedback_source_select;
    logic [1:0]             src;
    logic [5:0]             dlyp;
    logic [5:0]             dlys;
    logic [5:0]             dlyf;
    ccdm_div_t              dn;
    ccdm_div_t              dm;
    ccdm_div_t              du;
    ccdm_div_t              dv;
    logic [DLY_CYC_MAX-1:0] pp;
    logic [DLY_CYC_MAX-1:0] ps;
    logic [DLY_CYC_MAX-1:0] pf;
    logic [Q_W-1:0]         qcnt;
    logic [Q_W-1:0]         qper;
    logic [1:0]             phase;
    logic [1:0]             fbcnt;
    logic [5:0]             good;
    ccdm_lock_t             lk;
    logic                   lock;
    logic                   pd;
    logic [31:0]            prdata;
    logic                   o_p;
    logic                   o_s;
  } ccdm_st_t;

  ccdm_st_t r;
  ccdm_st_t next_r;

  // ****************************************
  // Functions
  // ****************************************
  // Toggle output every (rm1+1) input transitions: balanced duty
  function automatic ccdm_div_t div_step(ccdm_div_t s, logic in, logic [5:0] rm1);
    ccdm_div_t o;
    o = s;
    o.prev = in;
    if (in != s.prev) begin
      if (s.cnt >= rm1) begin
        o.cnt = 6'h00;
        o.out = ~s.out;
      end else begin
        o.cnt = s.cnt + 6'h01;
      end
    end
    return o;
  endfunction : div_step

  // Delay tap: steps of DLY_STEP_PS rounded up to whole cycles
  function automatic logic dly_tap(logic [DLY_CYC_MAX-1:0] p, logic in, logic [5:0] st);
    int steps;
    int cyc;
    steps = (int'(st) > DLY_STEPS_MAX) ? DLY_STEPS_MAX : int'(st);
    cyc   = (steps * DLY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (cyc > DLY_CYC_MAX) begin
      cyc = DLY_CYC_MAX;
    end
    if (cyc == 0) begin
      return in;
    end
    return p[cyc-1];
  endfunction : dly_tap

  // Shift a new sample into a delay pipe
  function automatic logic [DLY_CYC_MAX-1:0] dly_shift(logic [DLY_CYC_MAX-1:0] p, logic in);
    return DLY_CYC_MAX'({p, in});
  endfunction : dly_shift

  // ****************************************
  // Next state
  // ****************************************
  logic                   acc;
  logic                   hit;
  logic                   ce_mode;
  logic [3:0]             ce_n;
  logic [5:0]             ce_m;
  logic [1:0]             ce_u;
  logic [1:0]             ce_v;
  logic [2:0]             ce_psel;
  logic [1:0]             ce_ssel;
  logic [1:0]             ce_feedback_source_select;
  logic [1:0]             ce_src;
  logic [5:0]             ce_dlyp;
  logic [5:0]             ce_dlys;
  logic [5:0]             ce_dlyf;
  logic                   refc;
  logic                   pb;
  logic                   sb;
  logic                   pwr_dn;
  logic [1:0]             ph;
  logic                   oscp;
  logic                   osc0;
  logic                   fbin;
  logic                   ref_ev;
  logic                   fb_ev;
  logic                   pdl;
  logic                   sdl;

  // Register bus, configuration, loop and output paths
  always_comb begin
    next_r = r;
    next_r.s1 = {I_EXTERNAL_FEEDBACK_INPUT, I_SECONDARY_REFERENCE_CLOCK, I_INTERNAL_CLK,
                 I_DIFFERENTIAL_CLOCK_PAIR, I_GLOBAL_PAD_CLK};
    next_r.s2 = r.s1;

    // Effective configuration: static bits or registers
    ce_mode  = r.mode;
    ce_n     = ce_mode ? r.n_m1  : S_N;
    ce_m     = ce_mode ? r.m_m1  : S_M;
    ce_u     = ce_mode ? r.u_m1  : S_U;
    ce_v     = ce_mode ? r.v_m1  : S_V;
    ce_psel  = ce_mode ? r.psel  : P_PSEL;
    ce_ssel  = ce_mode ? r.ssel  : P_SSEL;
    ce_feedback_source_select = ce_mode ? r.feedback_source_select : P_FEEDBACK_SOURCE_SELECT;
    ce_src   = ce_mode ? r.src   : P_SRC;
    ce_dlyp  = ce_mode ? r.dlyp  : P_DLYP;
    ce_dlys  = ce_mode ? r.dlys  : P_DLYS;
    ce_dlyf  = ce_mode ? r.dlyf  : P_DLYF;

    // Reference source select
    unique case (ce_src)
      SRC_PAD:  refc = r.s2[SY_PAD];
      SRC_DIFF: refc = r.s2[SY_DIFF];
      SRC_INT:  refc = r.s2[SY_INT];
      SRC_NONE: refc = 1'b0;
    endcase

    // Bypass and power-down decisions
    pb     = ~ce_psel[2];
    sb     = (ce_ssel != SSEL_LOOP);
    pwr_dn = (pb & sb) | (ce_mode & r.pd_reg);
    next_r.pd = pwr_dn;

    // Oscillator: four quarter-period steps per cycle
    if (pwr_dn) begin
      next_r.qcnt  = '0;
      next_r.phase = 2'h0;
    end else if (r.qcnt >= r.qper - 16'h0001) begin
      next_r.qcnt  = '0;
      next_r.phase = r.phase + 2'h1;
    end else begin
      next_r.qcnt = r.qcnt + 16'h0001;
    end
    ph   = r.phase - ce_psel[1:0];
    oscp = ph[1];
    osc0 = r.phase[1];

    // Input and feedback dividers
    next_r.dn = div_step(r.dn, refc, {2'h0, ce_n});
    ref_ev    = next_r.dn.out & ~r.dn.out;
    next_r.pf = dly_shift(r.pf, osc0);
    unique case (ce_feedback_source_select)
      FEEDBACK_SOURCE_SELECT_GND: fbin = 1'b0;
      FEEDBACK_SOURCE_SELECT_DLY: fbin = dly_tap(r.pf, osc0, ce_dlyf);
      FEEDBACK_SOURCE_SELECT_PH0: fbin = osc0;
      FEEDBACK_SOURCE_SELECT_EXT: fbin = r.s2[SY_EXT];
    endcase
    next_r.dm = div_step(r.dm, fbin, ce_m);
    fb_ev     = next_r.dm.out & ~r.dm.out;

    // Loop tracking: one feedback edge per reference edge
    if (pwr_dn) begin
      next_r.lk    = LS_DOWN;
      next_r.good  = 6'h00;
      next_r.fbcnt = 2'h0;
    end else if (ref_ev) begin
      next_r.fbcnt = fb_ev ? 2'h1 : 2'h0;
      if (ce_feedback_source_select == FEEDBACK_SOURCE_SELECT_GND) begin
        next_r.good = 6'h00;
        next_r.lk   = LS_ACQ;
      end else if (r.fbcnt == 2'h0) begin
        if (r.qper > 16'h0001) begin
          next_r.qper = r.qper - 16'h0001;
        end
        next_r.good = 6'h00;
        next_r.lk   = LS_ACQ;
      end else if (r.fbcnt == 2'h1) begin
        if (r.good < 6'(LOCK_WINDOWS)) begin
          next_r.good = r.good + 6'h01;
        end
        next_r.lk = (r.good >= 6'(LOCK_WINDOWS - 1)) ? LS_LOCK : LS_ACQ;
      end else begin
        if (r.qper != '1) begin
          next_r.qper = r.qper + 16'h0001;
        end
        next_r.good = 6'h00;
        next_r.lk   = LS_ACQ;
      end
    end else begin
      if (fb_ev && r.fbcnt != 2'h3) begin
        next_r.fbcnt = r.fbcnt + 2'h1;
      end
      if (r.lk == LS_DOWN) begin
        next_r.lk = LS_ACQ;
      end
    end
    next_r.lock = (next_r.lk == LS_LOCK);

    // Primary path: bypass skips input divider
    next_r.du = div_step(r.du, pb ? refc : oscp, {4'h0, ce_u});
    next_r.pp = dly_shift(r.pp, r.du.out);
    pdl       = dly_tap(r.pp, r.du.out, ce_dlyp);
    if (ce_psel[2]) begin
      next_r.o_p = pdl;
    end else begin
      unique case (ce_psel)
        PSEL_BYP_DIV: next_r.o_p = r.du.out;
        PSEL_BYP_RAW: next_r.o_p = refc;
        PSEL_BYP_DLY: next_r.o_p = pdl;
        default:      next_r.o_p = 1'b0;
      endcase
    end

    // Secondary path: own reference only when bypassed
    next_r.dv = div_step(r.dv, sb ? r.s2[SY_REF2] : osc0, {4'h0, ce_v});
    next_r.ps = dly_shift(r.ps, r.dv.out);
    sdl       = dly_tap(r.ps, r.dv.out, ce_dlys);
    unique case (ce_ssel)
      SSEL_BYP_DIV: next_r.o_s = r.dv.out;
      SSEL_BYP_RAW: next_r.o_s = r.s2[SY_REF2];
      SSEL_BYP_DLY: next_r.o_s = sdl;
      SSEL_LOOP:    next_r.o_s = sdl;
    endcase

    // APB decode
    acc = I_PSEL & I_PENABLE;
    hit = (I_PADDR == OFS_CTRL) || (I_PADDR == OFS_DIV) || (I_PADDR == OFS_SEL) ||
          (I_PADDR == OFS_DLY) || (I_PADDR == OFS_STATUS);

    // Read data captured in the setup cycle
    if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      next_r.prdata = 32'h0000_0000;
      unique case (I_PADDR)
        OFS_CTRL: begin
          next_r.prdata[CTRL_MODE] = r.mode;
          next_r.prdata[CTRL_PD]   = r.pd_reg;
        end
        OFS_DIV: begin
          next_r.prdata[DIV_N+:4] = r.n_m1;
          next_r.prdata[DIV_M+:6] = r.m_m1;
          next_r.prdata[DIV_U+:2] = r.u_m1;
          next_r.prdata[DIV_V+:2] = r.v_m1;
        end
        OFS_SEL: begin
          next_r.prdata[SEL_P+:3]   = r.psel;
          next_r.prdata[SEL_S+:2]   = r.ssel;
          next_r.prdata[SEL_FB+:2]  = r.feedback_source_select;
          next_r.prdata[SEL_SRC+:2] = r.src;
        end
        OFS_DLY: begin
          next_r.prdata[DLY_P+:6] = r.dlyp;
          next_r.prdata[DLY_S+:6] = r.dlys;
          next_r.prdata[DLY_F+:6] = r.dlyf;
        end
        OFS_STATUS: begin
          next_r.prdata[4:0]          = {sb, pb, r.mode, r.pd, r.lock};
          next_r.prdata[STS_QPER+:16] = r.qper;
        end
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end

    // Writes take effect in the access cycle
    if (acc && I_PWRITE) begin
      unique case (I_PADDR)
        OFS_CTRL: begin
          next_r.mode   = I_PWDATA[CTRL_MODE];
          next_r.pd_reg = I_PWDATA[CTRL_PD];
        end
        OFS_DIV: begin
          next_r.n_m1 = I_PWDATA[DIV_N+:4];
          next_r.m_m1 = I_PWDATA[DIV_M+:6];
          next_r.u_m1 = I_PWDATA[DIV_U+:2];
          next_r.v_m1 = I_PWDATA[DIV_V+:2];
        end
        OFS_SEL: begin
          next_r.psel  = I_PWDATA[SEL_P+:3];
          next_r.ssel  = I_PWDATA[SEL_S+:2];
          next_r.feedback_source_select = I_PWDATA[SEL_FB+:2];
          next_r.src   = I_PWDATA[SEL_SRC+:2];
        end
        OFS_DLY: begin
          next_r.dlyp = I_PWDATA[DLY_P+:6];
          next_r.dlys = I_PWDATA[DLY_S+:6];
          next_r.dlyf = I_PWDATA[DLY_F+:6];
        end
        default: next_r.mode = r.mode;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      r       <= '0;
      r.psel  <= PSEL_PH0;
      r.ssel  <= SSEL_LOOP;
      r.feedback_source_select <= FEEDBACK_SOURCE_SELECT_PH0;
      r.qper  <= Q_RESET;
      r.lk    <= LS_DOWN;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign O_PRDATA                 = r.prdata;
  assign O_PREADY                 = 1'b1;     // Zero wait states
  assign O_PSLVERR                = acc & ~hit;
  assign O_PRIMARY_GLOBAL_CLOCK   = r.o_p;
  assign O_SECONDARY_GLOBAL_CLOCK = r.o_s;
  assign O_LOCK                   = r.lock;
  assign O_LOOP_POWER_DOWN        = r.pd;

endmodule : ccdm_clock_cond

// ### ccdm_clock_cond_tb.sv
// Self-checking bench for the clock conditioning block.
// Assumes the pin model ccdm_pads and the bound checker.
module ccdm_clock_cond_tb
  import ccdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 4096;
  logic        I_SYS_CLK = 1'b0;
  logic        I_SYS_RST = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, rnd = 32'h0000fd93;
  logic        pready, pslverr, prim, sec, lock, pd, e;
  logic [4:0]  pin;
  int          fail_count = 0, compares = 0, np, ns, u;
  logic [7:0]  ra [4] = '{OFS_CTRL, OFS_DIV, OFS_SEL, OFS_DLY};
  logic [31:0] rm [4] = '{32'h3, 32'h3fff, 32'h1ff, 32'h3ffff};
  logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h5c, 32'h0};

  // Clock
  always #4 I_SYS_CLK = !I_SYS_CLK;

  ccdm_clock_cond dut (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_GLOBAL_PAD_CLK(pin[0]), .I_DIFFERENTIAL_CLOCK_PAIR(pin[1]),
    .I_INTERNAL_CLK(pin[2]), .I_SECONDARY_REFERENCE_CLOCK(pin[3]), .I_EXTERNAL_FEEDBACK_INPUT(pin[4]),
    .O_PRIMARY_GLOBAL_CLOCK(prim), .O_SECONDARY_GLOBAL_CLOCK(sec), .O_LOCK(lock), .O_LOOP_POWER_DOWN(pd));
  ccdm_pads u_pads (.i_clk(I_SYS_CLK), .i_rst(I_SYS_RST), .o_pin(pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // Rising edges expected in one window
  function automatic int ex(int half, int mul, int div);
    return (half == 0) ? 0 : (WIN * mul) / (2 * half * div);
  endfunction : ex
  task automatic check(string what, logic [31:0] exp, logic [31:0] got, int tol = 0);
    compares++;
    if ((tol == 0) ? (got !== exp) : (int'(got) > int'(exp) + tol || int'(got) + tol < int'(exp))) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer, idle cycle first
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge I_SYS_CLK);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge I_SYS_CLK);
    penable <= 1'b1;
    do @(posedge I_SYS_CLK); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic count();
    logic lp, ls;
    np = 0;
    ns = 0;
    repeat (WIN) begin
      lp = prim;
      ls = sec;
      @(negedge I_SYS_CLK);
      np += int'(prim === 1'b1 && lp === 1'b0);
      ns += int'(sec === 1'b1 && ls === 1'b0);
    end
  endtask : count
  task automatic wait_lock();
    int k;
    k = 0;
    while (lock !== 1'b1 && k < 16000) begin
      @(posedge I_SYS_CLK);
      k++;
    end
    check("lock", 32'h1, {31'h0, lock});
  endtask : wait_lock
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #(95000 * 8);
    fail_count++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", rv[i], q);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status flags", 32'h0, q & 32'h1f);
    wait_lock();
    count();
    check("static primary", ex(32, 1, 1), np, 1);
    check("static secondary", ex(32, 1, 1), ns, 1);
    foreach (rv[i]) begin
      apb(1'b1, 8'h14 + 8'(i * 60), 32'hffffffff);
      check("unmapped error", 32'h1, {31'h0, e});
    end
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    check("status write error", 32'h0, {31'h0, e});
    apb(1'b0, 8'hfc, 32'h0);
    check("unmapped read", 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      u = int'(rnd[31:30]);
      apb(1'b1, ra[u], rnd & 32'hfffdf7df);
      apb(1'b0, ra[u], 32'h0);
      check("register readback", rnd & 32'hfffdf7df & rm[u], q);
    end
    rnd = xs(rnd);
    u = int'(rnd[1:0]) + 1;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_DIV, 32'h1031 | (32'(u - 1) << 10));
    apb(1'b1, OFS_SEL, 32'h5c);
    repeat (1024) @(posedge I_SYS_CLK);
    check("lock after ratio change", 32'h0, {31'h0, lock});
    for (int p = 4; p < 8; p++) begin
      apb(1'b1, OFS_SEL, 32'h58 | 32'(p));
      wait_lock();
      count();
      check("loop primary", ex(32, 4, 2 * u), np, 1);
      check("loop secondary", ex(32, 4, 4), ns, 1);
    end
    apb(1'b1, OFS_SEL, 32'h1c);
    repeat (3000) @(posedge I_SYS_CLK);
    check("grounded feedback lock", 32'h0, {31'h0, lock});
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_SEL, {8'h0, 8'h0, 16'({2'(i), 7'h48} | (i == 0 ? 16'h0 : i == 2 ? 16'h2 : 16'h1))});
      count();
      check("bypass primary", ex(i == 3 ? 0 : i == 1 ? 16 : i == 2 ? 40 : 32, 1, i == 1 ? 1 : u), np, 1);
      check("second reference", ex(24, 1, 1), ns, 1);
      check("bypass power down", 32'h1, {31'h0, pd});
    end
    apb(1'b1, OFS_SEL, 32'h5c);
    apb(1'b1, OFS_CTRL, 32'h3);
    count();
    check("requested power down", 32'h1, {31'h0, pd});
    check("powered down primary", 32'h0, np, 1);
    apb(1'b1, OFS_CTRL, 32'h0);
    wait_lock();
    count();
    check("back to static", ex(32, 1, 1), np, 1);
    check("power up", 32'h0, {31'h0, pd});
    print_verdict();
  end
endmodule : ccdm_clock_cond_tb

// ### ccdm_pads.sv
// Model of the clock pins feeding the block.
// Assumes the bench's system clock; half periods count sys cycles.
module ccdm_pads (
  // Timing
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Pad, differential, internal, second reference, external feedback
  output logic      [4:0] o_pin
);
  localparam int HALF [5] = '{32, 16, 40, 24, 32};
  int cnt [5];
  // Square waves well below the sys clock rate
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin <= 5'h00;
      cnt   <= '{default: 0};
    end else begin
      for (int k = 0; k < 5; k++) begin
        cnt[k] <= (cnt[k] == HALF[k] - 1) ? 0 : cnt[k] + 1;
        if (cnt[k] == HALF[k] - 1) o_pin[k] <= !o_pin[k];
      end
    end
  end
endmodule : ccdm_pads

// ### ccdm_pkg.sv
// Constants and types for the clock conditioning block.
// Assumes a 125 MHz system clock and an APB register slave.
package ccdm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int DLY_STEP_PS   = 250;
  localparam int DLY_MAX_PS    = 8000;
  localparam int DLY_STEPS_MAX = DLY_MAX_PS / DLY_STEP_PS;
  localparam int DLY_CYC_RAW   = (DLY_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLY_CYC_MAX   = (DLY_CYC_RAW < 1) ? 1 : DLY_CYC_RAW;
  localparam int LOCK_WINDOWS  = 32;  // Long enough that a one-step period error cannot look locked
  localparam int Q_W           = 16;
  localparam logic [15:0] Q_RESET = 16'h0040;

  // ****************************************
  // Divider limits
  // ****************************************
  localparam int IN_DIV_MAX  = 16;
  localparam int FB_MUL_MAX  = 64;
  localparam int OUT_DIV_MAX = 4;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DIV    = 8'h04;
  localparam logic [7:0] OFS_SEL    = 8'h08;
  localparam logic [7:0] OFS_DLY    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_MODE = 0;
  localparam int CTRL_PD   = 1;
  localparam int DIV_N     = 0;
  localparam int DIV_M     = 4;
  localparam int DIV_U     = 10;
  localparam int DIV_V     = 12;
  localparam int SEL_P     = 0;
  localparam int SEL_S     = 3;
  localparam int SEL_FB    = 5;
  localparam int SEL_SRC   = 7;
  localparam int DLY_P     = 0;
  localparam int DLY_S     = 6;
  localparam int DLY_F     = 12;
  localparam int STS_QPER  = 16;

  // ****************************************
  // Select codes
  // ****************************************
  localparam logic [2:0] PSEL_BYP_DIV = 3'h0;
  localparam logic [2:0] PSEL_BYP_RAW = 3'h1;
  localparam logic [2:0] PSEL_BYP_DLY = 3'h2;
  localparam logic [2:0] PSEL_RSVD    = 3'h3;
  localparam logic [2:0] PSEL_PH0     = 3'h4;
  localparam logic [1:0] SSEL_BYP_DIV = 2'h0;
  localparam logic [1:0] SSEL_BYP_RAW = 2'h1;
  localparam logic [1:0] SSEL_BYP_DLY = 2'h2;
  localparam logic [1:0] SSEL_LOOP    = 2'h3;
  localparam logic [1:0] FEEDBACK_SOURCE_SELECT_GND    = 2'h0;
  localparam logic [1:0] FEEDBACK_SOURCE_SELECT_DLY    = 2'h1;
  localparam logic [1:0] FEEDBACK_SOURCE_SELECT_PH0    = 2'h2;
  localparam logic [1:0] FEEDBACK_SOURCE_SELECT_EXT    = 2'h3;
  localparam logic [1:0] SRC_PAD      = 2'h0;
  localparam logic [1:0] SRC_DIFF     = 2'h1;
  localparam logic [1:0] SRC_INT      = 2'h2;
  localparam logic [1:0] SRC_NONE     = 2'h3;

  // Synchroniser bit positions
  localparam int SY_PAD  = 0;
  localparam int SY_DIFF = 1;
  localparam int SY_INT  = 2;
  localparam int SY_REF2 = 3;
  localparam int SY_EXT  = 4;

  // Loop tracking states
  typedef enum logic [2:0] {
    LS_DOWN = 3'b001,
    LS_ACQ  = 3'b010,
    LS_LOCK = 3'b100
  } ccdm_lock_t;

  // Integer divider state
  typedef struct packed {
    logic [5:0] cnt;
    logic       out;
    logic       prev;
  } ccdm_div_t;

endpackage : ccdm_pkg
